// ---- bpc_chk_assertions.sv ----
// Purpose: port checks of the byte-to-pixel converter
// Assumes: one clock, default sizing so the read threshold is 8
// Notes: bound to every converter instance
`timescale 1ns/1ps
module bpc_chk #(
   parameter bit DSI_MODE = 1'b0,
   parameter bit AXIS_RX_EN = 1'b0,
   parameter bit AXIS_TX_EN = 1'b0,
   parameter bit CTRL_POS = 1'b1,
   parameter int SYNC_DELAY = 5,
   parameter int TXW = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic short_packet_en_in,
   input wire logic [5:0] data_type_in,
   input wire logic payload_en_in,
   input wire logic axis_svalid,
   input wire logic axis_sready,
   input wire logic frame_valid_out,
   input wire logic line_valid_out,
   input wire logic vsync_out,
   input wire logic hsync_out,
   input wire logic display_data_enable,
   input wire logic [TXW-1:0] pixel_bus_out,
   input wire logic [1:0] pixel_odd_out,
   input wire logic axis_mvalid,
   input wire logic [TXW+1:0] axis_mdata
);
   localparam int SD1 = SYNC_DELAY + 1;
   logic [10:0] since;
   logic [5:0] last_dt;
   logic [7:0] words;
   logic de;
   default clocking dcb @(posedge clk); endclocking
   default disable iff (!nrst);
   // data enable per mode
   assign de = DSI_MODE ? display_data_enable : line_valid_out;
   // age of the newest short packet; saturates so old events fall silent
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         since <= 11'h7ff;
         last_dt <= 6'h00;
      end else if (short_packet_en_in) begin
         since <= 11'h001;
         last_dt <= data_type_in;
      end else if (since != 11'h7ff) begin
         since <= since + 11'h001;
      end
   end
   // payload words taken since reset, saturating
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         words <= 8'h00;
      end else if ((AXIS_RX_EN ? axis_svalid : payload_en_in) && words != 8'hff) begin
         words <= words + 8'h01;
      end
   end
   property p_ready;
      axis_sready;
   endproperty
   a_ready: assert property (p_ready) else $error("stream ready low");
   property p_mdata;
      axis_mdata == {pixel_odd_out, pixel_bus_out};
   endproperty
   a_mdata: assert property (p_mdata) else $error("stream word layout wrong");
   property p_mvalid;
      axis_mvalid == (AXIS_TX_EN && de);
   endproperty
   a_mvalid: assert property (p_mvalid) else $error("stream valid not data enable");
   property p_fs;
      !DSI_MODE && short_packet_en_in && data_type_in == 6'h00 |=> frame_valid_out == CTRL_POS;
   endproperty
   a_fs: assert property (p_fs) else $error("frame valid not raised");
   property p_fe;
      !DSI_MODE && short_packet_en_in && data_type_in == 6'h01 |=> frame_valid_out != CTRL_POS;
   endproperty
   a_fe: assert property (p_fe) else $error("frame valid not dropped");
   property p_quiet;
      DSI_MODE ? frame_valid_out != CTRL_POS : (vsync_out != CTRL_POS && hsync_out != CTRL_POS);
   endproperty
   a_quiet: assert property (p_quiet) else $error("sync of other mode active");
   property p_vs_on;
      DSI_MODE && since == SD1 && last_dt == 6'h01 |->
         vsync_out == CTRL_POS && hsync_out == CTRL_POS;
   endproperty
   a_vs_on: assert property (p_vs_on) else $error("vsync start not applied");
   property p_vs_off;
      DSI_MODE && since == SD1 && last_dt == 6'h11 |->
         vsync_out != CTRL_POS && hsync_out == CTRL_POS;
   endproperty
   a_vs_off: assert property (p_vs_off) else $error("vsync end not applied");
   property p_hold;
      DSI_MODE && since >= 3 && since <= SYNC_DELAY |-> $stable(vsync_out) && $stable(hsync_out);
   endproperty
   a_hold: assert property (p_hold) else $error("sync moved inside delay");
   property p_thr;
      $rose(de) |-> words >= 8'h08;
   endproperty
   a_thr: assert property (p_thr) else $error("read began below threshold");
   c_vs: cover property (DSI_MODE && since == SD1 && last_dt == 6'h01);
   c_de: cover property ($rose(de));
   c_fs: cover property (!DSI_MODE && frame_valid_out);
endmodule
bind bpc_top bpc_chk #(.DSI_MODE(DSI_MODE), .AXIS_RX_EN(AXIS_RX_EN), .AXIS_TX_EN(AXIS_TX_EN),
   .CTRL_POS(CTRL_POS), .SYNC_DELAY(SYNC_DELAY), .TXW(TXW)) u_bpc_chk (.clk(clk), .nrst(nrst),
   .short_packet_en_in(short_packet_en_in), .data_type_in(data_type_in),
   .payload_en_in(payload_en_in), .axis_svalid(axis_svalid), .axis_sready(axis_sready),
   .frame_valid_out(frame_valid_out), .line_valid_out(line_valid_out), .vsync_out(vsync_out),
   .hsync_out(hsync_out), .display_data_enable(display_data_enable),
   .pixel_bus_out(pixel_bus_out), .pixel_odd_out(pixel_odd_out), .axis_mvalid(axis_mvalid),
   .axis_mdata(axis_mdata));

// ---- bpc_fifo.sv ----
// Purpose: fifo between byte-side packer and pixel-side unpacker
// Assumes: width and depth set by the parent sizing
// Notes: one prefetched word sits in the output register
`timescale 1ns/1ps
`include "bpc_params.svh"
module bpc_fifo
   import bpc_pkg::*;
#(
   parameter int W = 8,
   parameter int DEPTH = 32,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready,
   output logic [AW+1:0] level
);
   typedef struct packed {
      logic [AW:0] wptr;
      logic [AW:0] rptr;
      logic ov;
   } bpc_fifo_st_t;

   bpc_fifo_st_t st, next_st;
   logic [AW:0] used;
   logic push, load;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("fifo depth must be a power of two");
   end

   // byte and pixel sides share clk here, so pointers compare directly
   always_comb begin
      used = st.wptr - st.rptr;
      in_ready = used != DEPTH[AW:0];
      push = in_valid && in_ready;
      load = (used != '0) && (!st.ov || out_ready);
      next_st = st;
      if (push) begin
         next_st.wptr = st.wptr + 1'b1;
      end
      if (load) begin
         next_st.rptr = st.rptr + 1'b1;
      end
      next_st.ov = load || (st.ov && !out_ready);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign out_valid = st.ov;
   assign level = {1'b0, used} + {{(AW+1){1'b0}}, st.ov};

   bpc_mem #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_mem (
      .clk(clk),
      .we(push),
      .waddr(st.wptr[AW-1:0]),
      .wdata(in_data),
      .re(load),
      .raddr(st.rptr[AW-1:0]),
      .rdata(out_data)
   );
endmodule

// ---- bpc_mem.sv ----
// Purpose: simple dual-port word store with registered read
// Assumes: one clock for both ports
// Notes: read data change only on a read strobe
`timescale 1ns/1ps
module bpc_mem #(
   parameter int W = 8,
   parameter int DEPTH = 32,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata
);
   logic [W-1:0] store [DEPTH];

   // no reset on the array, so it maps onto block memory
   always_ff @(posedge clk) begin
      if (we) begin
         store[waddr] <= wdata;
      end
      if (re) begin
         rdata <= store[raddr];
      end
   end
endmodule

// ---- bpc_params.svh ----
// Purpose: shared constants of the byte-to-pixel converter
// Assumes: included by bare name from design files
// Notes: definitions only
`ifndef BPC_PARAMS_SVH
`define BPC_PARAMS_SVH
// csi-2 short packet data types
`define BPC_DT_FRAME_START 6'h00
`define BPC_DT_FRAME_END 6'h01
// dsi short packet data types
`define BPC_DT_VSYNC_START 6'h01
`define BPC_DT_VSYNC_END 6'h11
`define BPC_DT_HSYNC_START 6'h21
`define BPC_DT_HSYNC_END 6'h31
// fifo sizing figures
`define BPC_EQ_THRESHOLD 4
`define BPC_EQ_DEPTH 16
`define BPC_DEPTH_PAD 6
`define BPC_BITS_PER_BYTE 8
`define BPC_RAW12_FACTOR 3
`define BPC_RAW14_FACTOR 7
`define BPC_RAW16_FACTOR 2
// effective byte factors as numerator over denominator
`define BPC_RGB666L_NUM 6
`define BPC_RGB666L_DEN 8
`define BPC_YCC20L_NUM 40
`define BPC_YCC20L_DEN 48
// dsi sync delay limits in pixel clocks
`define BPC_SYNC_DELAY_MIN 5
`define BPC_SYNC_DELAY_MAX 1023
`define BPC_SYNC_DELAY_DEF 5
// field positions of the stream receiver word above the payload
`define BPC_AXR_DT_POS 0
`define BPC_AXR_WC_POS 6
`define BPC_AXR_HDR_W 22
`endif

// ---- bpc_pkg.sv ----
// Purpose: types of the byte-to-pixel converter
// Assumes: nothing
// Notes: constants live in bpc_params.svh
package bpc_pkg;
   typedef enum logic [4:0] {
      fmt_rgb565, fmt_rgb666, fmt_rgb666_loose, fmt_rgb888, fmt_raw8, fmt_raw10,
      fmt_raw12, fmt_raw14, fmt_raw16, fmt_yuv420_8, fmt_yuv420_10, fmt_yuv422_8,
      fmt_yuv422_10, fmt_ycc422_16, fmt_ycc422_20_loose, fmt_ycc422_24
   } bpc_fmt_t;

   // latched long packet header
   typedef struct packed {
      logic [5:0] dt;
      logic [1:0] vc;
      logic [15:0] wc;
   } bpc_hdr_t;

   // pending dsi sync event
   typedef enum logic [2:0] {ev_none, ev_vs_start, ev_vs_end, ev_hs_start, ev_hs_end} bpc_ev_t;

   // ceiling division for sizing
   function automatic longint bpc_cdiv(input longint n, input longint d);
      return (n + d - 1) / d;
   endfunction
endpackage

// ---- bpc_src_model.sv ----
// Purpose: byte-side source standing in for the receiver byte logic
// Assumes: one packet at a time, called from the bench
// Notes: feeds native and stream ports alike; idle data is the inverse of the last word
`timescale 1ns/1ps
module bpc_src_model (
   input wire logic clk,
   output logic long_packet_active_in,
   output logic short_packet_en_in,
   output logic [5:0] data_type_in,
   output logic [1:0] virtual_channel_in,
   output logic [15:0] word_count_in,
   output logic payload_en_in,
   output logic [7:0] payload_in,
   output logic axis_svalid,
   output logic [29:0] axis_sdata
);
   logic [7:0] last = 8'h00;
   logic [5:0] cur_dt = 6'h18;
   logic [15:0] cur_wc = 16'h0000;
   // quiet lines at time zero
   initial begin
      long_packet_active_in = 1'b0;
      short_packet_en_in = 1'b0;
      data_type_in = 6'h00;
      virtual_channel_in = 2'h0;
      word_count_in = 16'h0000;
      payload_en_in = 1'b0;
      payload_in = 8'hff;
      axis_svalid = 1'b0;
      axis_sdata = 30'h0;
   end
   // one beat; idle data flips so a stale word is never mistaken for fresh
   task automatic beat(input logic v, input logic [7:0] d);
      logic [7:0] w;
      w = v ? d : ~last;
      if (v) last = d;
      payload_en_in <= v;
      axis_svalid <= v;
      payload_in <= w;
      axis_sdata <= {cur_wc, cur_dt, w};
   endtask
   // one-cycle short packet
   task automatic short_pkt(input logic [5:0] code);
      @(posedge clk);
      short_packet_en_in <= 1'b1;
      data_type_in <= code;
      @(posedge clk);
      short_packet_en_in <= 1'b0;
   endtask
   // long packet, at most one word a cycle so input never outruns an unstalled output
   task automatic send_line(input int n, input logic [7:0] base, input bit slow);
      cur_wc = 16'(n);
      @(posedge clk);
      long_packet_active_in <= 1'b1;
      data_type_in <= cur_dt;
      virtual_channel_in <= 2'h0;
      word_count_in <= cur_wc;
      for (int i = 0; i < n; i++) begin
         if (slow) begin
            beat(1'b0, 8'h00);
            @(posedge clk);
         end
         beat(1'b1, base + 8'(i));
         @(posedge clk);
      end
      long_packet_active_in <= 1'b0;
      beat(1'b0, 8'h00);
   endtask
endmodule

// ---- bpc_top.sv ----
// Purpose: byte-to-pixel converter, payload bytes in, pixel words and syncs out
// Assumes: byte and pixel logic both run on clk; fifo sizing fixed at elaboration
// Notes: per-format pixel packing is not done, words are sliced in order
// Operation
// - dsi vsync start packet raises both hsync and vsync.
// - dsi vsync end packet drops vsync and raises hsync.
// - sync outputs change only on matching received short packets.
// - dsi sync assertion delayed by a set number of pixel clocks.
// - payload latency after long packet enable is not fixed.
// - stream receiver ready stays 1; data taken whenever valid is high.
// - without stream receiver, payload and header come in on native ports.
// - stream transmitter word is odd flag above pixel bus.
// - stream transmitter valid follows the pixel data enable.
// - data enable is display enable in dsi, line valid in csi-2.
// - input width is lanes times gear; output width pixel width times lanes.
// - fifo width is smallest output-width multiple not below input width.
// - raw12, raw14, raw16 fifo width is 3, 7, 2 times input width.
// - effective byte factor 6/8, 40/48, else 1.
// - equal rates give threshold 4 and depth 16.
// - unequal rates use the ceiling formula; depth next power of two.
// - threshold clamped to ceiling of eight times word count over width.
// - yuv420 8 and 10 bit double depth and threshold.
// - pixel side reads only after fifo level reaches threshold.
`timescale 1ns/1ps
`include "bpc_params.svh"
module bpc_top
   import bpc_pkg::*;
#(
   parameter bpc_fmt_t DATA_TYPE = fmt_yuv420_8,
   parameter bit DSI_MODE = 1'b0,
   parameter int NUM_RX_LANE = 1,
   parameter int RX_GEAR = 8,
   parameter int PIXEL_BUS_WIDTH = 8,
   parameter int OUTPUT_PIXEL_LANES = 1,
   parameter int BYTE_MHZ = 100,
   parameter int PIXEL_MHZ = 100,
   parameter int WORD_COUNT = 5,
   parameter bit AXIS_RX_EN = 1'b0,
   parameter bit AXIS_TX_EN = 1'b0,
   parameter int SYNC_DELAY = `BPC_SYNC_DELAY_DEF,
   parameter bit CTRL_POS = 1'b1,
   parameter int RXW = NUM_RX_LANE * RX_GEAR,
   parameter int TXW = PIXEL_BUS_WIDTH * OUTPUT_PIXEL_LANES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic long_packet_active_in,
   input wire logic short_packet_en_in,
   input wire logic [5:0] data_type_in,
   input wire logic [5:0] second_data_type_in,
   input wire logic [1:0] virtual_channel_in,
   input wire logic [15:0] word_count_in,
   input wire logic [15:0] second_word_count_in,
   input wire logic payload_en_in,
   input wire logic [RXW-1:0] payload_in,
   input wire logic axis_svalid,
   input wire logic [RXW+`BPC_AXR_HDR_W-1:0] axis_sdata,
   output logic axis_sready,
   output bpc_hdr_t packet_header_out,
   output logic fifo_overflow,
   output logic frame_valid_out,
   output logic line_valid_out,
   output logic vsync_out,
   output logic hsync_out,
   output logic display_data_enable,
   output logic [TXW-1:0] pixel_bus_out,
   output logic [1:0] pixel_odd_out,
   output logic axis_mvalid,
   output logic [TXW+1:0] axis_mdata,
   input wire logic axis_mready
);
   // effective byte factor as a ratio
   localparam int UN = (DATA_TYPE == fmt_rgb666_loose) ? `BPC_RGB666L_NUM :
                       (DATA_TYPE == fmt_ycc422_20_loose) ? `BPC_YCC20L_NUM : 1;
   localparam int UD = (DATA_TYPE == fmt_rgb666_loose) ? `BPC_RGB666L_DEN :
                       (DATA_TYPE == fmt_ycc422_20_loose) ? `BPC_YCC20L_DEN : 1;

   // fifo word width
   localparam int FIFO_W =
      (DATA_TYPE == fmt_raw12) ? `BPC_RAW12_FACTOR * RXW :
      (DATA_TYPE == fmt_raw14) ? `BPC_RAW14_FACTOR * RXW :
      (DATA_TYPE == fmt_raw16) ? `BPC_RAW16_FACTOR * RXW :
      TXW * int'(bpc_cdiv(RXW, TXW));

   // rx rate scaled by UN and tx rate by UD so they stay integer
   localparam longint RX_RATE = longint'(RXW) * BYTE_MHZ * UN;
   localparam longint TX_RATE = longint'(TXW) * PIXEL_MHZ * UD;
   localparam bit RATES_EQ = RX_RATE == TX_RATE;
   localparam int YUV_MUL = (DATA_TYPE == fmt_yuv420_8 ||
                             DATA_TYPE == fmt_yuv420_10) ? 2 : 1;

   // threshold before the clamp; (N-1)/N equals (tx-rx)/tx
   function automatic longint thr_raw();
      longint num;
      longint den;
      longint t;
      num = longint'(`BPC_BITS_PER_BYTE) * WORD_COUNT * (TX_RATE - RX_RATE);
      den = TX_RATE * FIFO_W;
      if (RATES_EQ) begin
         t = `BPC_EQ_THRESHOLD;
      end else if (num >= 0) begin
         t = bpc_cdiv(num, den) + 1;
      end else begin
         t = num / den + 1;
      end
      return (t < 1) ? 1 : t;
   endfunction

   localparam longint THR_R = thr_raw();
   localparam longint WC_WORDS = bpc_cdiv(longint'(`BPC_BITS_PER_BYTE) * WORD_COUNT, FIFO_W);
   localparam longint THR_C = (THR_R * FIFO_W > longint'(`BPC_BITS_PER_BYTE) * WORD_COUNT) ?
                              WC_WORDS : THR_R;
   localparam int DEPTH = YUV_MUL * (RATES_EQ ? `BPC_EQ_DEPTH :
                          (1 << $clog2(THR_R + `BPC_DEPTH_PAD)));
   localparam int THR = YUV_MUL * int'(THR_C);
   localparam int AW = $clog2(DEPTH);
   localparam int K = FIFO_W / RXW;
   localparam int S = FIFO_W / TXW;
   localparam int CW = $clog2(K + 1);
   localparam int SW = $clog2(S + 1);

   if (FIFO_W % RXW != 0 || FIFO_W % TXW != 0 || THR > DEPTH ||
       SYNC_DELAY < `BPC_SYNC_DELAY_MIN || SYNC_DELAY > `BPC_SYNC_DELAY_MAX) begin : g_chk
      $error("unsupported converter configuration");
   end

   typedef struct packed {
      logic [FIFO_W-1:0] acc;
      logic [CW-1:0] n;
      logic full;
      logic in_pkt;
      bpc_hdr_t hdr;
      logic ovf;
      logic fv;
      logic vs;
      logic hs;
      bpc_ev_t ev;
      logic [9:0] cnt;
      logic started;
      logic hold;
      logic [FIFO_W-1:0] word;
      logic [SW-1:0] slice;
      logic de;
      logic [TXW-1:0] pix;
      logic [1:0] odd;
   } bpc_top_st_t;

   bpc_top_st_t st, next_st;
   logic din_valid;
   logic [RXW-1:0] din;
   bpc_hdr_t hdr_in;
   logic f_in_ready;
   logic f_out_valid;
   logic [FIFO_W-1:0] f_out_data;
   logic f_pop;
   logic [AW+1:0] f_level;
   logic tx_ready;
   logic adv;
   bpc_ev_t ev_in;

   // input selection between stream receiver and native ports
   always_comb begin
      axis_sready = 1'b1;
      if (AXIS_RX_EN) begin
         din_valid = axis_svalid;
         din = axis_sdata[RXW-1:0];
         hdr_in.dt = axis_sdata[RXW+`BPC_AXR_DT_POS +: 6];
         hdr_in.wc = axis_sdata[RXW+`BPC_AXR_WC_POS +: 16];
      end else begin
         din_valid = payload_en_in;
         din = payload_in;
         hdr_in.dt = data_type_in;
         hdr_in.wc = word_count_in;
      end
      hdr_in.vc = virtual_channel_in;
   end

   // dsi short packet decode
   always_comb begin
      ev_in = ev_none;
      if (DSI_MODE && short_packet_en_in) begin
         case (data_type_in)
            `BPC_DT_VSYNC_START: ev_in = ev_vs_start;
            `BPC_DT_VSYNC_END: ev_in = ev_vs_end;
            `BPC_DT_HSYNC_START: ev_in = ev_hs_start;
            `BPC_DT_HSYNC_END: ev_in = ev_hs_end;
            default: ev_in = ev_none;
         endcase
      end
   end

   // the output holds still while the stream sink stalls
   assign tx_ready = !AXIS_TX_EN || axis_mready;
   assign adv = !st.de || tx_ready;

   always_comb begin
      next_st = st;
      f_pop = 1'b0;

      // byte side: header is sampled on the first cycle of the long packet
      next_st.in_pkt = long_packet_active_in;
      if (long_packet_active_in && !st.in_pkt) begin
         next_st.hdr = hdr_in;
      end
      // packer: no fixed latency from packet start to fifo write
      if (st.full && f_in_ready) begin
         next_st.full = 1'b0;
         next_st.n = '0;
      end
      if (din_valid) begin
         if (!next_st.full) begin
            next_st.acc[int'(next_st.n)*RXW +: RXW] = din;
            next_st.n = next_st.n + 1'b1;
            next_st.full = next_st.n == CW'(K);
         end else begin
            next_st.ovf = 1'b1; // source has no ready, so a stalled word is lost
         end
      end
      // a short tail is pushed once the packet ends
      if (!long_packet_active_in && st.in_pkt && next_st.n != '0 && !next_st.full) begin
         next_st.full = 1'b1;
      end

      // csi-2 frame valid from frame start and end packets
      if (!DSI_MODE && short_packet_en_in) begin
         if (data_type_in == `BPC_DT_FRAME_START) begin
            next_st.fv = 1'b1;
         end else if (data_type_in == `BPC_DT_FRAME_END) begin
            next_st.fv = 1'b0;
         end
      end

      // dsi events wait out the sync delay; a newer packet replaces a pending one
      if (ev_in != ev_none) begin
         next_st.ev = ev_in;
         next_st.cnt = 10'(SYNC_DELAY - 1);
      end else if (st.ev != ev_none) begin
         if (st.cnt != '0) begin
            next_st.cnt = st.cnt - 1'b1;
         end else begin
            next_st.ev = ev_none;
            case (st.ev)
               ev_vs_start: begin
                  next_st.vs = 1'b1;
                  next_st.hs = 1'b1;
               end
               ev_vs_end: begin
                  next_st.vs = 1'b0;
                  next_st.hs = 1'b1;
               end
               ev_hs_start: next_st.hs = 1'b1;
               ev_hs_end: next_st.hs = 1'b0;
               default: next_st.hs = st.hs;
            endcase
         end
      end

      // pixel side: reading starts once the fill reaches the threshold
      if (!st.started && f_level >= (AW+2)'(THR)) begin
         next_st.started = 1'b1;
      end else if (st.started && !f_out_valid && !st.hold && !st.in_pkt && !st.full) begin
         next_st.started = 1'b0; // line drained, wait for the next fill
      end
      if (adv) begin
         if (st.hold) begin
            next_st.pix = st.word[int'(st.slice)*TXW +: TXW];
            next_st.odd = 2'(st.slice);
            next_st.de = 1'b1;
            next_st.slice = st.slice + 1'b1;
            if (st.slice == SW'(S - 1)) begin
               next_st.hold = 1'b0;
            end
         end else begin
            next_st.de = 1'b0;
         end
      end
      if (!next_st.hold && st.started && f_out_valid) begin
         f_pop = 1'b1;
         next_st.word = f_out_data;
         next_st.hold = 1'b1;
         next_st.slice = '0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   bpc_fifo #(.W(FIFO_W), .DEPTH(DEPTH), .AW(AW)) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_valid(st.full),
      .in_data(st.acc),
      .in_ready(f_in_ready),
      .out_valid(f_out_valid),
      .out_data(f_out_data),
      .out_ready(f_pop),
      .level(f_level)
   );

   // outputs; control polarity applied after the flops
   assign packet_header_out = st.hdr;
   assign fifo_overflow = st.ovf;
   assign frame_valid_out = DSI_MODE ? !CTRL_POS : (st.fv ~^ CTRL_POS);
   assign vsync_out = DSI_MODE ? (st.vs ~^ CTRL_POS) : !CTRL_POS;
   assign hsync_out = DSI_MODE ? (st.hs ~^ CTRL_POS) : !CTRL_POS;
   assign display_data_enable = DSI_MODE && st.de;
   assign line_valid_out = !DSI_MODE && st.de;
   assign pixel_bus_out = st.pix;
   assign pixel_odd_out = st.odd;
   assign axis_mvalid = AXIS_TX_EN && st.de;
   assign axis_mdata = {st.odd, st.pix};
endmodule

// ---- tb_top.sv ----
// Purpose: self-checking bench of the byte-to-pixel converter
// Assumes: csi instance on native ports, dsi instance on stream ports
// Notes: default sizing, threshold 8 and depth 32
`timescale 1ns/1ps
module tb_top;
   localparam int SD = 5;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic mready = 1'b1;
   int miscompares = 0;
   int check_count = 0;
   logic [9:0] q_c[$];
   logic [9:0] q_d[$];
   logic lpa, spe, pen, sval, c_fv, c_lv, c_ovf, d_vs, d_hs, d_mv, d_rdy, d_ovf;
   logic [5:0] dt;
   logic [1:0] vc;
   logic [15:0] wc;
   logic [7:0] pd;
   logic [7:0] c_pix;
   logic [29:0] sd;
   logic [23:0] c_hdr, d_hdr;
   logic [9:0] d_md;
   logic [1:0] prev = 2'b00;
   logic [5:0] codes [5] = '{6'h01, 6'h31, 6'h11, 6'h21, 6'h31};
   logic [1:0] vh [5] = '{2'b11, 2'b10, 2'b01, 2'b01, 2'b00};
   // 100 MHz clock
   always #5 clk = ~clk;
   bpc_src_model u_bpc_src_model (.clk(clk), .long_packet_active_in(lpa),
      .short_packet_en_in(spe), .data_type_in(dt), .virtual_channel_in(vc),
      .word_count_in(wc), .payload_en_in(pen), .payload_in(pd), .axis_svalid(sval),
      .axis_sdata(sd));
   bpc_top u_bpc_top (.clk(clk), .nrst(nrst), .long_packet_active_in(lpa),
      .short_packet_en_in(spe), .data_type_in(dt), .second_data_type_in(dt),
      .virtual_channel_in(vc), .word_count_in(wc), .second_word_count_in(wc),
      .payload_en_in(pen), .payload_in(pd), .axis_svalid(sval), .axis_sdata(sd),
      .axis_sready(), .packet_header_out(c_hdr), .fifo_overflow(c_ovf),
      .frame_valid_out(c_fv), .line_valid_out(c_lv), .vsync_out(), .hsync_out(),
      .display_data_enable(), .pixel_bus_out(c_pix), .pixel_odd_out(), .axis_mvalid(),
      .axis_mdata(), .axis_mready(mready));
   bpc_top #(.DSI_MODE(1'b1), .AXIS_RX_EN(1'b1), .AXIS_TX_EN(1'b1), .SYNC_DELAY(SD))
   u_bpc_top_dsi (.clk(clk), .nrst(nrst), .long_packet_active_in(lpa),
      .short_packet_en_in(spe), .data_type_in(dt), .second_data_type_in(dt),
      .virtual_channel_in(vc), .word_count_in(wc), .second_word_count_in(wc),
      .payload_en_in(pen), .payload_in(pd), .axis_svalid(sval), .axis_sdata(sd),
      .axis_sready(d_rdy), .packet_header_out(d_hdr), .fifo_overflow(d_ovf),
      .frame_valid_out(), .line_valid_out(), .vsync_out(d_vs), .hsync_out(d_hs),
      .display_data_enable(), .pixel_bus_out(), .pixel_odd_out(), .axis_mvalid(d_mv),
      .axis_mdata(d_md), .axis_mready(mready));
   // capture every pixel handed out, in order
   always @(posedge clk) begin
      if (c_lv === 1'b1) q_c.push_back({2'b00, c_pix});
      if (d_mv === 1'b1 && mready === 1'b1) q_d.push_back(d_md);
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // bounded wait for n captured pixels; a hang counts as a miss
   task automatic wait_px(input bit dsi, input int n);
      int t;
      t = 0;
      while ((dsi ? q_d.size() : q_c.size()) < n) begin
         @(posedge clk);
         t++;
         if (t > 400) begin
            miscompares++;
            test_done();
         end
      end
   endtask
   // pixels must come out whole and in order, odd flag zero with one slice a word
   task automatic chk_line(input bit dsi, input int n, input logic [7:0] base);
      logic [9:0] v;
      wait_px(dsi, n);
      for (int i = 0; i < n; i++) begin
         v = dsi ? q_d.pop_front() : q_c.pop_front();
         chk("pixel", v, {2'b00, base + 8'(i)});
      end
   endtask
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      u_bpc_src_model.short_pkt(6'h00);
      #1 chk("frame valid", c_fv, 1'b1);
      u_bpc_src_model.send_line(12, 8'h40, 1'b0);
      chk_line(1'b0, 12, 8'h40);
      chk_line(1'b1, 12, 8'h40);
      chk("header", c_hdr, {6'h18, 2'h0, 16'h000c});
      chk("stream header", d_hdr, {6'h18, 2'h0, 16'h000c});
      // slow source, line exactly at the threshold
      u_bpc_src_model.send_line(8, 8'h80, 1'b1);
      chk_line(1'b0, 8, 8'h80);
      chk_line(1'b1, 8, 8'h80);
      // stalled sink: stream side fills and overflows with ready still 1, native side drains
      @(posedge clk);
      mready <= 1'b0;
      u_bpc_src_model.send_line(40, 8'h00, 1'b0);
      chk_line(1'b0, 40, 8'h00);
      #1 chk("overflow", d_ovf, 1'b1);
      chk("stream ready", d_rdy, 1'b1);
      chk("native overflow", c_ovf, 1'b0);
      @(posedge clk);
      mready <= 1'b1;
      chk_line(1'b1, 32, 8'h00);
      repeat (20) @(posedge clk);
      q_d.delete();
      // every dsi sync code, held through the delay then applied
      for (int k = 0; k < 5; k++) begin
         u_bpc_src_model.short_pkt(codes[k]);
         repeat (SD - 1) @(posedge clk);
         #1 chk("sync held", {d_vs, d_hs}, prev);
         @(posedge clk);
         #1 chk("sync", {d_vs, d_hs}, vh[k]);
         prev = vh[k];
      end
      chk("frame valid end", c_fv, 1'b0);
      // reset in mid-run clears the sticky flag and the header
      @(posedge clk);
      nrst <= 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      #1 chk("overflow after reset", d_ovf, 1'b0);
      chk("header after reset", c_hdr, 24'h000000);
      test_done();
   end
endmodule
